/* core/lpa_defines.svh */
// timing counts, field positions and limits of the link pulse negotiator
`ifndef LPA_DEFINES_SVH
`define LPA_DEFINES_SVH

// clock periods and documented times, in ns
`define LPA_LINK_NS      12
`define LPA_PULSE_NS     100
`define LPA_SLOT_NS      62500
`define LPA_BURST_NS     16000000
`define LPA_NLP_MIN_NS   8000000
`define LPA_NLP_MAX_NS   24000000

// burst shape and handshake counts
`define LPA_POS_LAST     6'h20
`define LPA_MATCH_N      2'h3
`define LPA_CACK_N       3'h6
`define LPA_NLP_N        2'h3
`define LPA_XHOLD        3'h7

// code word layout
`define LPA_SEL_LSB      0
`define LPA_ABIL_LSB     5
`define LPA_RF_BIT       13
`define LPA_ACK_BIT      14
`define LPA_NP_BIT       15
`define LPA_SEL_ETH      5'h01
`define LPA_ACK_MASK     16'h4000

// ability bit positions inside the technology field
`define LPA_A_10         0
`define LPA_A_10FD       1
`define LPA_A_TX         2
`define LPA_A_TXFD       3
`define LPA_A_T4         4

`endif

/* core/lpa_pkg.sv */
// types shared by the link pulse negotiator modules
package lpa_pkg;
  // negotiation progress, one-hot
  typedef enum logic [5:0] {
    LPA_ST_ABIL = 6'h01,
    LPA_ST_ACK  = 6'h02,
    LPA_ST_CACK = 6'h04,
    LPA_ST_GOOD = 6'h08,
    LPA_ST_NLP  = 6'h10,
    LPA_ST_PD   = 6'h20
  } lpa_state_e;

  // which single pma owns the mdi
  typedef enum logic [2:0] {
    LPA_PMA_NONE = 3'h0,
    LPA_PMA_10T  = 3'h1,
    LPA_PMA_TX   = 3'h2,
    LPA_PMA_T4   = 3'h4
  } lpa_pma_e;

  typedef logic [15:0] lpa_word_t;
endpackage

/* core/lpa_link_if.sv */
// signals between the negotiator core and its link-clock helpers
`timescale 1ns/1ps
`default_nettype none
interface lpa_link_if;
  logic              link_ce;   // clock enable, link domain
  logic              tx_en;     // burst enable, link domain
  lpa_pkg::lpa_word_t word;     // code word, stable around toggle
  logic              word_tgl;  // flips when word changes
  logic              done_tgl;  // flips at each burst end
  logic              nlp_tgl;   // flips on legacy link detect

  modport gen (input link_ce, input tx_en, input word,
               input word_tgl, output done_tgl);
  modport det (input link_ce, output nlp_tgl);
  modport top (output link_ce, output tx_en, output word,
               output word_tgl, input done_tgl, input nlp_tgl);
endinterface
`default_nettype wire

/* core/lpa_flp_tx.sv */
// fast link pulse burst generator on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "lpa_defines.svh"
module lpa_flp_tx #(
  parameter int unsigned SLOT_CYC  = 5208,
  parameter int unsigned BURST_CYC = 1333333,
  parameter int unsigned PW_CYC    = 8
) (
  // clock and reset
  input  wire logic link_clk,
  input  wire logic rst_b,
  // core side
  lpa_link_if.gen   lk,
  // mdi pulse
  output logic      flp_pulse
);
  localparam int SW = $clog2(SLOT_CYC + 1);
  localparam int IW = $clog2(BURST_CYC + 1);
  localparam int PWW = $clog2(PW_CYC + 1);

  logic [2:0]         tg_r;      // word toggle sync plus edge stage
  lpa_pkg::lpa_word_t word_r;    // word used by bursts
  logic [IW-1:0]      ival_r;    // burst start to burst start
  logic [SW-1:0]      slot_r;    // pulse position spacing
  logic [5:0]         pos_r;     // position 0..32 within burst
  logic               burst_r;   // burst in progress
  logic [PWW-1:0]     pw_r;      // pulse width count
  logic               fire;      // a pulse starts now
  logic               done_r;

  assign lk.done_tgl = done_r;
  // clock slots pulse, data only for ones, lsb first
  assign fire = burst_r && (slot_r == '0) &&
                (!pos_r[0] || word_r[pos_r[4:1]]);

  // word crossing: copy only once the toggle has settled
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      tg_r   <= 3'h0;
      word_r <= 16'h0000;
    end else if (lk.link_ce) begin
      tg_r <= {tg_r[1:0], lk.word_tgl};
      if (tg_r[2] ^ tg_r[1])
        word_r <= lk.word;
    end
  end

  // burst and slot timing from local counters
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ival_r  <= '0;
      slot_r  <= '0;
      pos_r   <= 6'h00;
      burst_r <= 1'b0;
      done_r  <= 1'b0;
    end else if (lk.link_ce) begin
      if (!lk.tx_en) begin
        ival_r  <= '0;
        burst_r <= 1'b0;
      end else if (ival_r == '0) begin
        ival_r  <= IW'(BURST_CYC - 1);
        burst_r <= 1'b1;
        pos_r   <= 6'h00;
        slot_r  <= '0;
      end else begin
        ival_r <= ival_r - 1'b1;
        if (burst_r) begin
          if (slot_r == SW'(SLOT_CYC - 1)) begin
            slot_r <= '0;
            if (pos_r == `LPA_POS_LAST) begin
              burst_r <= 1'b0;
              done_r  <= ~done_r;
            end else
              pos_r <= pos_r + 6'h01;
          end else
            slot_r <= slot_r + 1'b1;
        end
      end
    end
  end

  // pulse of fixed width; never a lone legacy pulse
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      flp_pulse <= 1'b0;
      pw_r      <= '0;
    end else if (lk.link_ce) begin
      if (!lk.tx_en) begin
        flp_pulse <= 1'b0;
        pw_r      <= '0;
      end else if (fire) begin
        flp_pulse <= 1'b1;
        pw_r      <= PWW'(PW_CYC - 1);
      end else if (pw_r != '0)
        pw_r <= pw_r - 1'b1;
      else
        flp_pulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* core/lpa_nlp_rx.sv */
// legacy single link pulse integrity detector on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "lpa_defines.svh"
module lpa_nlp_rx #(
  parameter int unsigned NLP_MIN_CYC = 666666,
  parameter int unsigned NLP_MAX_CYC = 2000000
) (
  // clock and reset
  input  wire logic link_clk,
  input  wire logic rst_b,
  // mdi receive pulse, asynchronous
  input  wire logic rx_pulse,
  // core side
  lpa_link_if.det   lk
);
  localparam int GW = $clog2(NLP_MAX_CYC + 1);

  logic [2:0]    rx_r;   // two sync stages plus edge stage
  logic [GW-1:0] gap_r;  // cycles since last pulse, saturating
  logic [1:0]    cnt_r;  // isolated pulses in a row
  logic          nlp_r;
  logic          rise;

  assign lk.nlp_tgl = nlp_r;
  assign rise = rx_r[1] & ~rx_r[2];

  // a pulse counts only when spaced like a legacy link pulse;
  // burst pulses arrive far closer and clear the count
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_r  <= 3'h0;
      gap_r <= '0;
      cnt_r <= 2'h0;
      nlp_r <= 1'b0;
    end else if (lk.link_ce) begin
      rx_r <= {rx_r[1:0], rx_pulse};
      if (rise) begin
        gap_r <= '0;
        if (gap_r >= GW'(NLP_MIN_CYC) && gap_r <= GW'(NLP_MAX_CYC)) begin
          if (cnt_r == `LPA_NLP_N - 2'h1)
            nlp_r <= ~nlp_r;
          else
            cnt_r <= cnt_r + 2'h1;
        end else
          cnt_r <= 2'h0;
      end else if (gap_r != GW'(NLP_MAX_CYC))
        gap_r <= gap_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* core/lpa_autoneg.sv */
// link pulse negotiation core: handshake, resolution and pma switch
//
// Contract
// - one burst every 16 ms, 8 ms slack
// - pulse positions spaced 62.5 us, 7 us slack
// - legacy pulses seen: stop bursts, enable 10t
// - no 10t pma: still stop bursts
// - never send legacy single link pulses
// - confirm partner word with acknowledge bit set
// - enable best common mode after both acknowledge
// - no bursts once mode enabled
// - bursts only for link startup, none in good
// - first bursts carry base code word
// - mask abilities, never advertise missing ones
// - 33 positions, odd ones clock, even data
// - data pulse means one, gap means zero
// - legacy receive link integrity test present
// - parallel detect 100tx and t4 partners only
// - link tests only for supported technologies
// - mdi goes to exactly one pma; none is enabled while negotiating, or on legacy pulses with no 10t pma
// - works without any management agent
// - clock pulses 125 us apart, burst starts clock
// - zero bit: no pulse 111 us after clock
// - code word sent lsb first
`timescale 1ns/1ps
`default_nettype none
`include "lpa_defines.svh"
module lpa_autoneg #(
  // which pmas exist beside the negotiator
  parameter bit          HAS_10T     = 1'b1,
  parameter bit          HAS_TX      = 1'b1,
  parameter bit          HAS_T4      = 1'b0,
  parameter bit          HAS_FD      = 1'b1,
  // link clock counts, shortened in simulation
  parameter int unsigned SLOT_CYC    = `LPA_SLOT_NS / `LPA_LINK_NS,
  parameter int unsigned BURST_CYC   = `LPA_BURST_NS / `LPA_LINK_NS,
  parameter int unsigned NLP_MIN_CYC =
    (`LPA_NLP_MIN_NS + `LPA_LINK_NS - 1) / `LPA_LINK_NS,
  parameter int unsigned NLP_MAX_CYC = `LPA_NLP_MAX_NS / `LPA_LINK_NS
) (
  // system clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // link clock
  input  wire logic       link_clk,
  // optional management, may be tied off
  input  wire logic       restart,
  input  wire logic [7:0] adv_mask,
  input  wire logic       remote_fault,
  // receive decoder, same clock
  input  wire logic       rx_word_valid,
  input  wire logic [15:0] rx_word,
  // pma link status, same clock
  input  wire logic       tx_link_ready,
  input  wire logic       t4_link_ready,
  // mdi
  input  wire logic       rx_pulse,
  output logic            flp_pulse,
  // pma control and status
  output logic [2:0]      pma_en,
  output logic            pma_fd,
  output logic            an_complete,
  output logic            ack_sent,
  output logic [15:0]     lp_word
);
  localparam int unsigned PW_CYC = `LPA_PULSE_NS / `LPA_LINK_NS;

  // refuse counts the burst timing cannot honour
  generate
    if (SLOT_CYC < 2 * PW_CYC + 2)
      $error("slot count too small for pulse width");
    if (BURST_CYC < 34 * SLOT_CYC)
      $error("burst period shorter than a burst");
    if (NLP_MIN_CYC <= 3 * SLOT_CYC || NLP_MAX_CYC < NLP_MIN_CYC)
      $error("legacy pulse window overlaps burst spacing");
  endgenerate

  lpa_link_if lk ();

  // ---- helpers -------------------------------------------------
  // best common mode, highest priority first; bit 3 is full duplex
  function automatic logic [3:0] pick_mode(input logic [7:0] c);
    logic [3:0] m;
    m = {1'b0, lpa_pkg::LPA_PMA_NONE};
    if (c[`LPA_A_TXFD])
      m = {1'b1, lpa_pkg::LPA_PMA_TX};
    else if (c[`LPA_A_T4])
      m = {1'b0, lpa_pkg::LPA_PMA_T4};
    else if (c[`LPA_A_TX])
      m = {1'b0, lpa_pkg::LPA_PMA_TX};
    else if (c[`LPA_A_10FD])
      m = {1'b1, lpa_pkg::LPA_PMA_10T};
    else if (c[`LPA_A_10])
      m = {1'b0, lpa_pkg::LPA_PMA_10T};
    return m;
  endfunction

  // compare two code words with the acknowledge bit ignored
  function automatic logic same_word(input logic [15:0] a,
                                     input logic [15:0] b);
    return (a & ~`LPA_ACK_MASK) == (b & ~`LPA_ACK_MASK);
  endfunction

  // ---- local and advertised abilities --------------------------
  logic [7:0] local_abil;  // what the pmas really do
  logic [7:0] adv_abil;    // what goes into the word
  logic [7:0] common;      // shared with partner
  logic [3:0] hcd;         // resolved mode

  // built from the pmas present, so a missing one is never offered
  always_comb begin
    local_abil = 8'h00;
    local_abil[`LPA_A_10]   = HAS_10T;
    local_abil[`LPA_A_10FD] = HAS_10T & HAS_FD;
    local_abil[`LPA_A_TX]   = HAS_TX;
    local_abil[`LPA_A_TXFD] = HAS_TX & HAS_FD;
    local_abil[`LPA_A_T4]   = HAS_T4;
  end

  // masking only removes bits
  assign adv_abil = local_abil & adv_mask;
  assign common   = adv_abil &
                    lp_word[`LPA_ABIL_LSB +: 8];
  assign hcd      = pick_mode(common);

  // ---- clock enable and burst enable into the link domain ------
  logic [1:0] ce_s_r;   // ce sync, link side
  logic [1:0] en_s_r;   // burst enable sync, link side
  logic       burst_en; // system side request level

  assign lk.link_ce = ce_s_r[1];
  assign lk.tx_en   = en_s_r[1];

  // plain two-stage level crossings
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ce_s_r <= 2'h0;
      en_s_r <= 2'h0;
    end else begin
      ce_s_r <= {ce_s_r[0], ce};
      en_s_r <= {en_s_r[0], burst_en};
    end
  end

  // ---- link events back into the system domain -----------------
  logic [2:0] done_s_r; // burst end toggle sync plus edge stage
  logic [2:0] nlp_s_r;  // legacy detect toggle sync plus edge stage
  logic       done_ev;  // one burst has finished
  logic       nlp_ev;   // legacy link seen

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_s_r <= 3'h0;
      nlp_s_r  <= 3'h0;
    end else if (ce) begin
      done_s_r <= {done_s_r[1:0], lk.done_tgl};
      nlp_s_r  <= {nlp_s_r[1:0], lk.nlp_tgl};
    end
  end

  // edges taken between second and third stage only
  assign done_ev = ce & (done_s_r[2] ^ done_s_r[1]);
  assign nlp_ev  = ce & (nlp_s_r[2] ^ nlp_s_r[1]);

  // ---- state -----------------------------------------------------
  lpa_pkg::lpa_state_e state_r;   // negotiation phase
  lpa_pkg::lpa_state_e state_nxt;
  logic [1:0]          match_r;   // consistent words in a row
  logic [15:0]         last_r;    // previous received word
  logic                flp_seen_r;// partner negotiates
  logic [2:0]          cack_r;    // bursts after partner ack
  logic                pd_hit;    // one non-negotiating pma up
  logic                rx_ack_ok; // partner acks our word

  // parallel detect only for supported pmas, and only one at a time
  assign pd_hit = !flp_seen_r &&
                  ((tx_link_ready & HAS_TX) ^
                   (t4_link_ready & HAS_T4));

  assign rx_ack_ok = rx_word_valid && rx_word[`LPA_ACK_BIT] &&
                     same_word(rx_word, last_r);

  // next phase
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lpa_pkg::LPA_ST_ABIL: begin
        if (nlp_ev)
          state_nxt = lpa_pkg::LPA_ST_NLP;
        else if (pd_hit)
          state_nxt = lpa_pkg::LPA_ST_PD;
        else if (match_r == `LPA_MATCH_N)
          state_nxt = lpa_pkg::LPA_ST_ACK;
      end
      lpa_pkg::LPA_ST_ACK: begin
        if (nlp_ev)
          state_nxt = lpa_pkg::LPA_ST_NLP;
        else if (rx_ack_ok)
          state_nxt = lpa_pkg::LPA_ST_CACK;
      end
      lpa_pkg::LPA_ST_CACK: begin
        // a few more acked bursts so the partner also completes
        if (done_ev && cack_r == `LPA_CACK_N - 3'h1) begin
          if (hcd[2:0] != lpa_pkg::LPA_PMA_NONE)
            state_nxt = lpa_pkg::LPA_ST_GOOD;
          else
            state_nxt = lpa_pkg::LPA_ST_ABIL;
        end
      end
      lpa_pkg::LPA_ST_GOOD: state_nxt = state_r;
      lpa_pkg::LPA_ST_NLP:  state_nxt = state_r;
      lpa_pkg::LPA_ST_PD:   state_nxt = state_r;
      default:              state_nxt = lpa_pkg::LPA_ST_ABIL;
    endcase
    // restart always wins, back to the base word
    if (restart)
      state_nxt = lpa_pkg::LPA_ST_ABIL;
  end

  // phase register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      state_r <= lpa_pkg::LPA_ST_ABIL;
    else if (ce)
      state_r <= state_nxt;
  end

  // consistency count over received words, ack bit ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      match_r    <= 2'h0;
      last_r     <= 16'h0000;
      flp_seen_r <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        match_r    <= 2'h0;
        flp_seen_r <= 1'b0;
      end else if (rx_word_valid) begin
        flp_seen_r <= 1'b1;
        last_r     <= rx_word;
        if (!same_word(rx_word, last_r))
          match_r <= 2'h1;
        else if (match_r != `LPA_MATCH_N)
          match_r <= match_r + 2'h1;
      end
    end
  end

  // partner word kept once it is trusted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      lp_word <= 16'h0000;
    else if (ce) begin
      if (restart)
        lp_word <= 16'h0000;
      else if (state_r == lpa_pkg::LPA_ST_ABIL &&
               match_r == `LPA_MATCH_N)
        lp_word <= last_r;
    end
  end

  // bursts sent after the partner acknowledged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      cack_r <= 3'h0;
    else if (ce) begin
      if (state_r != lpa_pkg::LPA_ST_CACK)
        cack_r <= 3'h0;
      else if (done_ev)
        cack_r <= cack_r + 3'h1;
    end
  end

  // ---- transmit word and its crossing ----------------------------
  logic [15:0] word_nxt;  // word we want on the wire
  logic [15:0] word_r;    // word offered to the link side
  logic        wtgl_r;    // change marker
  logic [2:0]  hold_r;    // spacing between changes

  // next page unsupported, so that bit stays low
  always_comb begin
    word_nxt = 16'h0000;
    word_nxt[`LPA_SEL_LSB +: 5]  = `LPA_SEL_ETH;
    word_nxt[`LPA_ABIL_LSB +: 8] = adv_abil;
    word_nxt[`LPA_RF_BIT]        = remote_fault;
    word_nxt[`LPA_ACK_BIT]       = ack_sent;
    word_nxt[`LPA_NP_BIT]        = 1'b0;
  end

  // changes are spaced so the link side copies a settled word;
  // the cost is a short lag after a mask or ack change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_r <= 16'h0000;
      wtgl_r <= 1'b0;
      hold_r <= 3'h0;
    end else if (ce) begin
      if (hold_r != 3'h0)
        hold_r <= hold_r - 3'h1;
      else if (word_nxt != word_r) begin
        word_r <= word_nxt;
        wtgl_r <= ~wtgl_r;
        hold_r <= `LPA_XHOLD;
      end
    end
  end

  assign lk.word     = word_r;
  assign lk.word_tgl = wtgl_r;

  // ack bit is set in the ack and complete-ack phases, cleared elsewhere
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ack_sent <= 1'b0;
    else if (ce)
      ack_sent <= (state_nxt == lpa_pkg::LPA_ST_ACK) ||
                  (state_nxt == lpa_pkg::LPA_ST_CACK);
  end

  // bursts only while negotiating
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      burst_en <= 1'b0;
    else if (ce)
      burst_en <= (state_nxt == lpa_pkg::LPA_ST_ABIL) ||
                  (state_nxt == lpa_pkg::LPA_ST_ACK) ||
                  (state_nxt == lpa_pkg::LPA_ST_CACK);
  end

  // ---- transmit switch: one pma at most owns the mdi -------------
  // held off during negotiation so the burst generator is alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pma_en <= lpa_pkg::LPA_PMA_NONE;
      pma_fd <= 1'b0;
    end else if (ce) begin
      case (state_nxt)
        lpa_pkg::LPA_ST_GOOD: begin
          pma_en <= hcd[2:0];
          pma_fd <= hcd[3];
        end
        lpa_pkg::LPA_ST_NLP: begin
          pma_en <= HAS_10T ? lpa_pkg::LPA_PMA_10T
                            : lpa_pkg::LPA_PMA_NONE;
          pma_fd <= 1'b0;
        end
        lpa_pkg::LPA_ST_PD: begin
          // picked on entry only: a later ready drop must not switch pma
          if (state_r != lpa_pkg::LPA_ST_PD)
            pma_en <= (tx_link_ready & HAS_TX) ? lpa_pkg::LPA_PMA_TX
                                                : lpa_pkg::LPA_PMA_T4;
          pma_fd <= 1'b0;
        end
        default: begin
          pma_en <= lpa_pkg::LPA_PMA_NONE;
          pma_fd <= 1'b0;
        end
      endcase
    end
  end

  // completion flag for the pma side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      an_complete <= 1'b0;
    else if (ce)
      an_complete <= (state_nxt == lpa_pkg::LPA_ST_GOOD);
  end

  // ---- link-clock helpers -----------------------------------------
  // pulse trains counted on the link clock
  lpa_flp_tx #(
    .SLOT_CYC  (SLOT_CYC),
    .BURST_CYC (BURST_CYC),
    .PW_CYC    (PW_CYC)
  ) u_tx (
    .link_clk  (link_clk),
    .rst_b     (rst_b),
    .lk        (lk.gen),
    .flp_pulse (flp_pulse)
  );

  // legacy link pulse detection
  lpa_nlp_rx #(
    .NLP_MIN_CYC (NLP_MIN_CYC),
    .NLP_MAX_CYC (NLP_MAX_CYC)
  ) u_nlp (
    .link_clk (link_clk),
    .rst_b    (rst_b),
    .rx_pulse (rx_pulse),
    .lk       (lk.det)
  );
endmodule
`default_nettype wire

/* verification/lpa_props.sv */
// port checker for the link pulse negotiator
`timescale 1ns/1ps
`default_nettype none
module lpa_props #(parameter int unsigned SLOT_CYC = 40) (
  // clocks and reset
  input wire logic       clk,
  input wire logic       link_clk,
  input wire logic       rst_b,
  // requests
  input wire logic       restart,
  input wire logic       rx_word_valid,
  // results
  input wire logic       flp_pulse,
  input wire logic [2:0] pma_en,
  input wire logic       an_complete,
  input wire logic       ack_sent
);
  logic [7:0] lo_n; // quiet link cycles, saturating
  // gap counter, reloads on every pulse cycle
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) lo_n <= 8'hff;
    else if (flp_pulse) lo_n <= 8'h00;
    else if (lo_n != 8'hff) lo_n <= lo_n + 8'h01;
  end
  sequence s_pulse;
    flp_pulse [*8] ##1 !flp_pulse;
  endsequence
  a_one_pma: assert property (
    @(posedge clk) disable iff (!rst_b) $onehot0(pma_en))
    else $error("pma enable not one-hot");
  a_pma_held: assert property (
    @(posedge clk) disable iff (!rst_b)
    pma_en != 3'h0 && !restart |=> $stable(pma_en))
    else $error("pma changed without restart");
  a_restart_clears: assert property (
    @(posedge clk) disable iff (!rst_b)
    restart |=> !ack_sent && !an_complete && pma_en == 3'h0)
    else $error("restart left state set");
  a_ack_after_word: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(ack_sent) |-> $past(rx_word_valid, 2))
    else $error("ack without received word");
  a_good_after_ack: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(an_complete) |-> $past(ack_sent) && pma_en != 3'h0)
    else $error("complete without ack or pma");
  a_quiet_when_done: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    (pma_en != 3'h0) [*8] |-> !flp_pulse)
    else $error("burst after pma enabled");
  a_pulse_width: assert property (
    @(posedge link_clk) disable iff (!rst_b || pma_en != 3'h0)
    $rose(flp_pulse) |-> s_pulse)
    else $error("pulse width wrong");
  a_slot_gap: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    $rose(flp_pulse) |-> lo_n == SLOT_CYC - 8 || lo_n >= 2 * SLOT_CYC - 8)
    else $error("pulse spacing wrong");
endmodule
bind lpa_autoneg lpa_props #(.SLOT_CYC(SLOT_CYC)) u_props (.clk(clk),
  .link_clk(link_clk), .rst_b(rst_b), .restart(restart),
  .rx_word_valid(rx_word_valid), .flp_pulse(flp_pulse), .pma_en(pma_en),
  .an_complete(an_complete), .ack_sent(ack_sent));
`default_nettype wire

/* verification/lpa_far_end.sv */
// far end partner: burst decoder and legacy pulse source
`timescale 1ns/1ps
`default_nettype none
module lpa_far_end (
  // link clock
  input wire logic   link_clk,
  // line
  input wire logic   flp_pulse,
  output logic       rx_pulse,
  // control and view
  input wire logic   nlp_on,
  output logic [15:0] seen_word,
  output int         seen_n
);
  int          gap = 9999; // cycles since last rise
  int          pos = 0;    // burst position
  int          nt = 0;     // legacy pulse timer
  logic [15:0] w = 16'h0000;
  logic        f_q = 1'b0;
  initial begin
    seen_n = 0;
    seen_word = 16'h0000;
    rx_pulse = 1'b0;
  end
  // decode by rise spacing; only whole bursts are published
  always @(posedge link_clk) begin
    f_q <= flp_pulse;
    gap = gap + 1;
    if (flp_pulse && !f_q) begin
      if (gap > 150) begin
        if (pos == 32) begin
          seen_word <= w;
          seen_n <= seen_n + 1;
        end
        pos = 0;
        w = 16'h0000;
      end else pos = pos + ((gap > 60) ? 2 : 1);
      if (pos[0]) w[pos/2] = 1'b1;
      gap = 0;
    end
  end
  // legacy pulse each 500 link cycles
  always @(posedge link_clk) begin
    nt <= (nt == 499) ? 0 : nt + 1;
    rx_pulse <= nlp_on && (nt < 8);
  end
endmodule
`default_nettype wire

/* verification/test_link_pulse_autoneg_transmit.sv */
// self-checking bench for the link pulse negotiator
`timescale 1ns/1ps
`default_nettype none
module test_link_pulse_autoneg_transmit;
  logic clk = 0, link_clk = 0, rst_b = 0, ce = 1, restart = 0;
  logic remote_fault = 0, rx_word_valid = 0, nlp_on = 0, tx_link_ready = 0;
  logic [7:0] adv_mask = 8'hff;
  logic [15:0] rx_word = 16'h0000, lp_word, seen_word, pw;
  logic flp_pulse, rx_pulse, pma_fd, an_complete, ack_sent;
  logic [2:0] pma_en;
  logic [31:0] rng = 32'h0000_001b;
  int bad_count = 0, check_count = 0, cyc = 0, seen_n, n0, pk;
  lpa_autoneg #(.SLOT_CYC(40), .BURST_CYC(1500), .NLP_MIN_CYC(200),
    .NLP_MAX_CYC(2000)) DUT (.clk(clk), .rst_b(rst_b), .ce(ce),
    .link_clk(link_clk), .restart(restart), .adv_mask(adv_mask),
    .remote_fault(remote_fault), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .tx_link_ready(tx_link_ready), .t4_link_ready(1'b0),
    .rx_pulse(rx_pulse), .flp_pulse(flp_pulse), .pma_en(pma_en),
    .pma_fd(pma_fd), .an_complete(an_complete), .ack_sent(ack_sent),
    .lp_word(lp_word));
  lpa_far_end far (.link_clk(link_clk), .flp_pulse(flp_pulse),
    .rx_pulse(rx_pulse), .nlp_on(nlp_on), .seen_word(seen_word),
    .seen_n(seen_n));
  initial forever #5 clk = ~clk;
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // advertised word model: selector, masked local abilities, fault
  function automatic logic [15:0] xw();
    return {2'h0, remote_fault, 4'h0, adv_mask[3:0], 5'h01};
  endfunction
  // priority model, returns pma code twice plus duplex
  function automatic int pick(logic [4:0] c);
    if (c[3]) return 5;
    if (c[4]) return 8;
    if (c[2]) return 4;
    if (c[1]) return 3;
    return c[0] ? 2 : 0;
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic send(logic [15:0] w, int n);
    repeat (n) begin
      @(posedge clk);
      rx_word_valid <= 1'b1;
      rx_word <= w;
    end
    @(posedge clk);
    rx_word_valid <= 1'b0;
  endtask
  task automatic bursts(int n);
    n0 = seen_n;
    wait (seen_n >= n0 + n);
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pw = 16'(rnd());
      adv_mask <= pw[7:0];
      remote_fault <= pw[8];
      bursts(3);
      chk("tx word", xw(), seen_word);
    end
    @(posedge clk);
    adv_mask <= adv_mask | 8'h01;
    pw = (16'(rnd()) & 16'h03e0) | 16'h0021;
    send(pw, 3);
    repeat (2) @(posedge clk);
    chk("ack", 16'h0001, ack_sent);
    chk("lp word", pw, lp_word);
    bursts(3);
    chk("ack word", xw() | 16'h4000, seen_word);
    send(pw | 16'h4000, 1);
    wait (an_complete === 1'b1);
    #1;
    pk = pick(pw[9:5] & adv_mask[4:0] & 5'h0f);
    chk("pma", 16'(pk >> 1), pma_en);
    chk("fd", 16'(pk & 1), pma_fd);
    n0 = seen_n;
    repeat (4000) @(posedge clk);
    chk("good bursts", 16'(n0), 16'(seen_n));
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    #1;
    chk("ack clr", 16'h0000, ack_sent);
    chk("pma clr", 16'h0000, pma_en);
    bursts(3);
    chk("base word", xw(), seen_word);
    nlp_on <= 1'b1;
    wait (pma_en === 3'h1);
    n0 = seen_n;
    repeat (4000) @(posedge clk);
    chk("nlp bursts", 16'(n0), 16'(seen_n));
    chk("nlp pma", 16'h0001, pma_en);
    nlp_on <= 1'b0;
    tx_link_ready <= 1'b1;
    repeat (20) @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pd pma", 16'h0002, pma_en);
    chk("pd fd", 16'h0000, pma_fd);
    end_sim();
  end
endmodule
`default_nettype wire
